//--- common/devctl_pkg.sv
`default_nettype none
package devctl_pkg;
  // Bus geometry
  localparam int unsigned ADR_W = 12;
  localparam int unsigned N_ERR = 4;
  // Register byte addresses
  localparam logic [11:0] DEVCTL_OFF = 12'h0c8;
  localparam logic [11:0] IRQ_STS_OFF = 12'h100;
  localparam logic [11:0] IRQ_CLR_OFF = 12'h104;
  localparam logic [11:0] IRQ_EN_OFF = 12'h108;
  // Control field positions (low half of the word)
  localparam int unsigned ERR_EN_LSB = 0;
  localparam int unsigned RELAX_ORD_BIT = 4;
  localparam int unsigned MPS_LSB = 5;
  localparam int unsigned EXT_TAG_BIT = 8;
  localparam int unsigned PHANTOM_BIT = 9;
  localparam int unsigned AUX_PM_BIT = 10;
  localparam int unsigned NO_SNOOP_BIT = 11;
  localparam int unsigned MRRS_LSB = 12;
  // Status field positions (high half of the word)
  localparam int unsigned ERR_DET_LSB = 16;
  localparam int unsigned AUX_DET_BIT = 20;
  localparam int unsigned TRANS_PEND_BIT = 21;
  // Reset and fixed values
  localparam logic [3:0] ERR_EN_RST = 4'h0;
  localparam logic [2:0] MPS_RST = 3'h0;
  localparam logic [2:0] MRRS_FIXED = 3'h0;
  localparam logic AUX_PM_RST = 1'b0;
  localparam logic AUX_DET_RST = 1'b1;
  localparam logic TRANS_PEND_FIXED = 1'b0;
  localparam logic [3:0] IRQ_EN_RST = 4'h0;
  // Supported payload limit per strap level
  localparam logic [2:0] MPS_SUP_STRAP0 = 3'h1;
  localparam logic [2:0] MPS_SUP_STRAP1 = 3'h2;
endpackage : devctl_pkg
`default_nettype wire

//--- common/err_flags_if.sv
`default_nettype none
interface err_flags_if;
  logic [3:0] evt;
  logic [3:0] dev_clr;
  logic [3:0] irq_clr;
  logic [3:0] dev_sts;
  logic [3:0] irq_sts;
  modport capture (input evt, input dev_clr, input irq_clr, output dev_sts, output irq_sts);
  modport owner (output evt, output dev_clr, output irq_clr, input dev_sts, input irq_sts);
endinterface : err_flags_if
`default_nettype wire

//--- design/err_flag_capture.sv
`default_nettype none
module err_flag_capture (
  input wire logic clk_i,
  input wire logic rst_i,
  err_flags_if.capture flags
);
  typedef struct packed {
    logic [3:0] dev_sts;
    logic [3:0] irq_sts;
  } cap_state_s;

  cap_state_s st_r;
  cap_state_s st_nxt;

  // Sticky flags: a detection in the same cycle as a clear keeps the flag set
  always_comb
  begin
    st_nxt = st_r;
    for (int k = 0; k < 4; k++)
    begin
      st_nxt.dev_sts[k] = flags.evt[k] | (st_r.dev_sts[k] & ~flags.dev_clr[k]);
      st_nxt.irq_sts[k] = flags.evt[k] | (st_r.irq_sts[k] & ~flags.irq_clr[k]);
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Flag outputs
  assign flags.dev_sts = st_r.dev_sts;
  assign flags.irq_sts = st_r.irq_sts;
endmodule : err_flag_capture
`default_nettype wire

//--- design/switch_port_device_ctrl_status.sv
// Notes on behaviour
// - Four error reporting enables, bits 0-3, reset 0
// - Relaxed ordering bit 4 reads zero always
// - Payload limit bits 7:5, reset 0, clamped
// - Extended tag and phantom bits read zero
// - Aux power permit bit 10, writable, resets 0
// - No-snoop bit 11 reads zero always
// - Read request size bits 14:12 fixed zero
// - Error detected bits set on event, write-one-clear
// - Aux power detected bit 20, read-only, reset 1
// - Transactions pending bit 21 fixed zero
// - Supported payload limit follows strap: 1 or 2
//
// Chosen here: the Wishbone interface to the registers.
`default_nettype none
module switch_port_device_ctrl_status (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [3:0] err_event_i,
  input wire logic payload_strap_i,
  input wire logic aux_power_detect_i,
  output logic [3:0] err_report_en_o,
  output logic [2:0] max_payload_o,
  output logic aux_power_pm_permit_o,
  output logic irq_o
);
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic [3:0] err_en;
    logic [2:0] mps;
    logic aux_pm;
    logic aux_det;
    logic [2:0] mps_sup;
    logic [3:0] irq_en;
    logic irq;
  } ctl_state_s;

  ctl_state_s st_r;
  ctl_state_s st_nxt;
  err_flags_if flags ();

  logic req;
  logic wr;
  logic hit_dev;
  logic hit_ists;
  logic hit_iclr;
  logic hit_ien;
  logic [31:0] dev_word;
  logic [2:0] mps_wr;

  // Bus request decode: one access per handshake, ack drops the cycle after
  assign req = wb_cyc_i & wb_stb_i & ~st_r.ack;
  assign wr = req & wb_we_i;
  assign hit_dev = (wb_adr_i[11:2] == devctl_pkg::DEVCTL_OFF[11:2]);
  assign hit_ists = (wb_adr_i[11:2] == devctl_pkg::IRQ_STS_OFF[11:2]);
  assign hit_iclr = (wb_adr_i[11:2] == devctl_pkg::IRQ_CLR_OFF[11:2]);
  assign hit_ien = (wb_adr_i[11:2] == devctl_pkg::IRQ_EN_OFF[11:2]);

  // Payload write value clamped to the supported limit
  assign mps_wr = (wb_dat_i[7:5] > st_r.mps_sup) ? st_r.mps_sup : wb_dat_i[7:5];

  // Clear strobes towards the sticky flags; zero bits leave flags alone
  assign flags.evt = err_event_i;
  assign flags.dev_clr = (wr & hit_dev & wb_sel_i[2]) ? wb_dat_i[19:16] : 4'h0;
  assign flags.irq_clr = (wr & hit_iclr & wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0;

  // Combined control and status word; fixed and reserved bits read zero
  always_comb
  begin
    dev_word = 32'h0000_0000;
    dev_word[devctl_pkg::ERR_EN_LSB +: 4] = st_r.err_en;
    dev_word[devctl_pkg::RELAX_ORD_BIT] = 1'b0;
    dev_word[devctl_pkg::MPS_LSB +: 3] = st_r.mps;
    dev_word[devctl_pkg::EXT_TAG_BIT] = 1'b0;
    dev_word[devctl_pkg::PHANTOM_BIT] = 1'b0;
    dev_word[devctl_pkg::AUX_PM_BIT] = st_r.aux_pm;
    dev_word[devctl_pkg::NO_SNOOP_BIT] = 1'b0;
    dev_word[devctl_pkg::MRRS_LSB +: 3] = devctl_pkg::MRRS_FIXED;
    dev_word[devctl_pkg::ERR_DET_LSB +: 4] = flags.dev_sts;
    dev_word[devctl_pkg::AUX_DET_BIT] = st_r.aux_det;
    dev_word[devctl_pkg::TRANS_PEND_BIT] = devctl_pkg::TRANS_PEND_FIXED;
  end

  // Next state: bus slave, control fields, interrupt
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ack = req;
    st_nxt.dat = 32'h0000_0000;
    st_nxt.mps_sup = payload_strap_i ? devctl_pkg::MPS_SUP_STRAP1
                                     : devctl_pkg::MPS_SUP_STRAP0;
    st_nxt.aux_det = aux_power_detect_i;
    if (req & ~wb_we_i)
    begin
      if (hit_dev)
      begin
        st_nxt.dat = dev_word;
      end
      else if (hit_ists)
      begin
        st_nxt.dat = {28'h0000000, flags.irq_sts};
      end
      else if (hit_ien)
      begin
        st_nxt.dat = {28'h0000000, st_r.irq_en};
      end
    end
    if (wr & hit_dev & wb_sel_i[0])
    begin
      st_nxt.err_en = wb_dat_i[3:0];
      st_nxt.mps = mps_wr;
    end
    if (wr & hit_dev & wb_sel_i[1])
    begin
      st_nxt.aux_pm = wb_dat_i[devctl_pkg::AUX_PM_BIT];
    end
    if (wr & hit_ien & wb_sel_i[0])
    begin
      st_nxt.irq_en = wb_dat_i[3:0];
    end
    st_nxt.irq = |(flags.irq_sts & st_r.irq_en);
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r.ack <= 1'b0;
      st_r.dat <= 32'h0000_0000;
      st_r.err_en <= devctl_pkg::ERR_EN_RST;
      st_r.mps <= devctl_pkg::MPS_RST;
      st_r.aux_pm <= devctl_pkg::AUX_PM_RST;
      st_r.aux_det <= devctl_pkg::AUX_DET_RST;
      st_r.mps_sup <= devctl_pkg::MPS_SUP_STRAP0;
      st_r.irq_en <= devctl_pkg::IRQ_EN_RST;
      st_r.irq <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Sticky error flags
  err_flag_capture u_capture (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flags(flags.capture)
  );

  // Outputs straight from flops
  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.dat;
  assign err_report_en_o = st_r.err_en;
  assign max_payload_o = st_r.mps;
  assign aux_power_pm_permit_o = st_r.aux_pm;
  assign irq_o = st_r.irq;

  // Ack is a single-cycle pulse
  a_ack_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // Every request is answered on the next edge
  a_ack_after_req: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not answered next cycle");

  // Read data stay zero outside the ack cycle
  a_ack_data_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
    else $error("read data nonzero without ack");

  // A write answer carries no data
  a_write_no_data: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && $past(wb_we_i)) |-> (wb_dat_o == 32'h0000_0000))
    else $error("write answered with data");

  // Enables take the written low nibble
  a_enable_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_dev && wb_sel_i[0]) |=> (err_report_en_o == $past(wb_dat_i[3:0])))
    else $error("reporting enables not written");

  // Enables move only on a low-byte write
  a_enable_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && hit_dev && wb_sel_i[0]) |=> $stable(err_report_en_o))
    else $error("reporting enables changed without a write");

  // Reset clears the enables and the interrupt
  a_enable_reset: assert property (@(posedge clk_i)
    rst_i |=> (err_report_en_o == devctl_pkg::ERR_EN_RST && !irq_o))
    else $error("reporting enables not reset");

  // Hardwired requester controls read zero
  a_fixed_bits_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && $past(hit_dev && !wb_we_i)) |->
      (wb_dat_o[4] == 1'b0 && wb_dat_o[9:8] == 2'b00 && wb_dat_o[15:11] == 5'h00))
    else $error("hardwired control bit read nonzero");

  // Pending flag and reserved status bits read zero
  a_status_fixed: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && $past(hit_dev && !wb_we_i)) |-> (wb_dat_o[31:21] == 11'h000))
    else $error("reserved or pending status bit nonzero");

  // Unmapped and write-only addresses read zero
  a_unmapped_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && !$past(hit_dev || hit_ists || hit_ien)) |-> (wb_dat_o == 32'h0000_0000))
    else $error("unmapped address read nonzero");

  // Oversized payload values store the supported limit
  a_payload_clamp: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_dev && wb_sel_i[0] && wb_dat_i[7:5] > st_r.mps_sup) |=>
      (max_payload_o == $past(st_r.mps_sup)))
    else $error("payload limit not clamped");

  // Legal payload values are stored unchanged
  a_payload_pass: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_dev && wb_sel_i[0] && wb_dat_i[7:5] <= st_r.mps_sup) |=>
      (max_payload_o == $past(wb_dat_i[7:5])))
    else $error("legal payload value not stored");

  // Payload field moves only on a low-byte write
  a_payload_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && hit_dev && wb_sel_i[0]) |=> $stable(max_payload_o))
    else $error("payload limit changed without a write");

  // Strap high selects the larger supported limit
  a_strap_limit: assert property (@(posedge clk_i) disable iff (rst_i)
    payload_strap_i |=> (st_r.mps_sup == devctl_pkg::MPS_SUP_STRAP1))
    else $error("supported limit does not follow strap");

  // Strap low selects the smaller supported limit
  a_strap_low: assert property (@(posedge clk_i) disable iff (rst_i)
    !payload_strap_i |=> (st_r.mps_sup == devctl_pkg::MPS_SUP_STRAP0))
    else $error("supported limit does not follow low strap");

  // Permit bit takes bit 10 of a second-byte write
  a_permit_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_dev && wb_sel_i[1]) |=>
      (aux_power_pm_permit_o == $past(wb_dat_i[devctl_pkg::AUX_PM_BIT])))
    else $error("aux power permit not written");

  // Permit bit is sticky between writes
  a_permit_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && hit_dev && wb_sel_i[1]) |=> $stable(aux_power_pm_permit_o))
    else $error("aux power permit changed without a write");

  // Reset clears permit and payload field
  a_aux_perm_reset: assert property (@(posedge clk_i)
    rst_i |=> (aux_power_pm_permit_o == 1'b0 && max_payload_o == 3'h0))
    else $error("control fields not reset");

  // Aux power detected reads one out of reset
  a_aux_det_reset: assert property (@(posedge clk_i)
    rst_i |=> (st_r.aux_det == 1'b1))
    else $error("aux power detected not reset to one");

  // Aux power detected tracks its input one cycle late
  a_det_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> (st_r.aux_det == $past(aux_power_detect_i)))
    else $error("aux power detected does not follow input");

  // Word read shows the registered detect bit
  a_read_aux_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && $past(hit_dev && !wb_we_i)) |-> (wb_dat_o[20] == $past(st_r.aux_det)))
    else $error("aux power detected misread");

  // A fatal error sets its flag and keeps it
  a_error_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    err_event_i[2] |=> flags.dev_sts[2] [*1] ##1 (flags.dev_sts[2] || $past(flags.dev_clr[2])))
    else $error("fatal error flag not held");

  // Writing one clears a flag with no new event
  a_err_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (flags.dev_sts[2] && flags.dev_clr[2] && !flags.evt[2]) |=> !flags.dev_sts[2])
    else $error("fatal error flag not cleared");

  // Event and clear in one cycle leave the flag set
  a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    (flags.evt[1] && flags.dev_clr[1]) |=> flags.dev_sts[1])
    else $error("clear won over a new event");

  // Word read shows the detected-error flags
  a_read_status_bits: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && $past(hit_dev && !wb_we_i)) |-> (wb_dat_o[19:16] == $past(flags.dev_sts)))
    else $error("error flags misread");

  // Writing zero leaves a status flag alone
  a_zero_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
    (flags.dev_sts[0] && flags.dev_clr[0] == 1'b0) |=> flags.dev_sts[0])
    else $error("flag lost without a one written");

  // Interrupt flag survives without a one written
  a_irq_flag_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
    (flags.irq_sts[3] && !flags.irq_clr[3]) |=> flags.irq_sts[3])
    else $error("interrupt flag lost without a one written");

  // Reset clears every sticky flag
  a_flags_reset: assert property (@(posedge clk_i)
    rst_i |=> (flags.dev_sts == 4'h0 && flags.irq_sts == 4'h0))
    else $error("sticky flags not reset");

  // Enabled flag raises the interrupt next cycle
  a_irq_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    (|(flags.irq_sts & st_r.irq_en)) |=> irq_o)
    else $error("interrupt not raised for enabled flag");

  // No enabled flag drops the interrupt next cycle
  a_irq_low: assert property (@(posedge clk_i) disable iff (rst_i)
    !(|(flags.irq_sts & st_r.irq_en)) |=> !irq_o)
    else $error("interrupt high without an enabled flag");
endmodule : switch_port_device_ctrl_status
`default_nettype wire

//--- verification/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] err_event_i = 4'h0;
  logic payload_strap_i = 1'b0;
  logic aux_power_detect_i = 1'b1;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [3:0] err_report_en_o;
  logic [2:0] max_payload_o;
  logic aux_power_pm_permit_o;
  logic irq_o;
  int fails = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'haefa;
  logic [31:0] rd;
  logic [3:0] en_m = 4'h0;
  logic [2:0] mps_m = 3'h0;
  logic pm_m = 1'b0;
  logic [3:0] sts_m = 4'h0;
  logic [3:0] ists_m = 4'h0;
  logic [3:0] ien_m = 4'h0;
  logic [31:0] corner [4] = '{32'hffffffff, 32'h0, 32'h00000060, 32'h00007ba0};

  switch_port_device_ctrl_status switch_port_device_ctrl_status_i (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .err_event_i,
    .payload_strap_i, .aux_power_detect_i, .err_report_en_o, .max_payload_o,
    .aux_power_pm_permit_o, .irq_o);

  // Free-running clock
  initial forever #2 clk_i = ~clk_i;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Payload field limited to what the strap supports
  function automatic logic [2:0] clamp(input logic [2:0] v, input logic strap);
    logic [2:0] lim;
    lim = strap ? 3'h2 : 3'h1;
    return (v > lim) ? lim : v;
  endfunction : clamp

  // Whole word expected at the control and status address
  function automatic logic [31:0] exp_word();
    return {11'h000, aux_power_detect_i, sts_m, 5'h00, pm_m, 2'h0, mps_m, 1'b0, en_m};
  endfunction : exp_word

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask : cmp

  // One classic cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [11:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1)
    begin
      $display("[ERR] wb_ack_o expected 1 seen %b", wb_ack_o);
      fails++;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
    wb(1'b0, a, 4'hf, 32'h0);
    cmp(nm, e, rd);
  endtask : rd_chk

  // Control write, model update and output check
  task automatic wr_ctrl(input logic [3:0] s, input logic [31:0] d);
    wb(1'b1, devctl_pkg::DEVCTL_OFF, s, d);
    if (s[0])
    begin
      en_m = d[3:0];
      mps_m = clamp(d[7:5], payload_strap_i);
    end
    if (s[1])
      pm_m = d[10];
    if (s[2])
      sts_m = sts_m & ~d[19:16];
    cmp("err_report_en_o", {28'h0, en_m}, {28'h0, err_report_en_o});
    cmp("max_payload_o", {29'h0, mps_m}, {29'h0, max_payload_o});
    cmp("permit", {31'h0, pm_m}, {31'h0, aux_power_pm_permit_o});
    rd_chk("control word", devctl_pkg::DEVCTL_OFF, exp_word());
  endtask : wr_ctrl

  task automatic pulse(input logic [3:0] v);
    @(posedge clk_i);
    err_event_i <= v;
    @(posedge clk_i);
    err_event_i <= 4'h0;
    sts_m = sts_m | v;
    ists_m = ists_m | v;
  endtask : pulse

  task automatic chk_irq();
    @(posedge clk_i);
    #1;
    cmp("irq_o", {31'h0, |(ists_m & ien_m)}, {31'h0, irq_o});
  endtask : chk_irq

  task automatic irq_wr(input logic [11:0] a, input logic [3:0] v);
    wb(1'b1, a, 4'hf, {28'h0, v});
    if (a == devctl_pkg::IRQ_EN_OFF)
      ien_m = v;
    else
      ists_m = ists_m & ~v;
    chk_irq();
  endtask : irq_wr

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  // Watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fails++;
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("reset word", devctl_pkg::DEVCTL_OFF, exp_word());
    for (int i = 0; i < 14; i++)
    begin
      seed = lfsr(seed);
      payload_strap_i <= (i < 4) ? i[0] : seed[31];
      repeat (2) @(posedge clk_i);
      wr_ctrl((i < 4) ? 4'hf : seed[3:0], (i < 4) ? corner[i] : seed);
    end
    irq_wr(devctl_pkg::IRQ_EN_OFF, 4'h0);
    pulse(4'h5);
    chk_irq();
    rd_chk("status", devctl_pkg::DEVCTL_OFF, exp_word());
    rd_chk("irq status", devctl_pkg::IRQ_STS_OFF, {28'h0, ists_m});
    irq_wr(devctl_pkg::IRQ_EN_OFF, 4'h4);
    wr_ctrl(4'h4, 32'h0);
    wr_ctrl(4'h4, 32'h00050000);
    irq_wr(devctl_pkg::IRQ_CLR_OFF, 4'h1);
    irq_wr(devctl_pkg::IRQ_CLR_OFF, 4'h4);
    pulse(4'ha);
    irq_wr(devctl_pkg::IRQ_EN_OFF, 4'hf);
    rd_chk("irq enable", devctl_pkg::IRQ_EN_OFF, 32'hf);
    // Event held across a clear of the same flag: the set wins
    @(posedge clk_i);
    err_event_i <= 4'h2;
    sts_m = sts_m | 4'h2;
    ists_m = ists_m | 4'h2;
    wb(1'b1, devctl_pkg::DEVCTL_OFF, 4'h4, 32'h00020000);
    err_event_i <= 4'h0;
    rd_chk("set wins", devctl_pkg::DEVCTL_OFF, exp_word());
    wr_ctrl(4'hf, 32'hfff0fc1f);
    wb(1'b1, 12'h0c4, 4'hf, 32'hffffffff);
    rd_chk("unmapped", 12'h0c4, 32'h0);
    aux_power_detect_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd_chk("aux detected", devctl_pkg::DEVCTL_OFF, exp_word());
    // Mid-run reset returns every field to its reset value
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    en_m = 4'h0;
    mps_m = 3'h0;
    pm_m = 1'b0;
    sts_m = 4'h0;
    ists_m = 4'h0;
    ien_m = 4'h0;
    chk_irq();
    cmp("permit", {31'h0, pm_m}, {31'h0, aux_power_pm_permit_o});
    rd_chk("after reset", devctl_pkg::DEVCTL_OFF, exp_word());
    rd_chk("irq enable reset", devctl_pkg::IRQ_EN_OFF, 32'h0);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
